// *** lofc_top.sv ***
// lofc_top: apb register bank and lane formatter for the lvds output port
// Functional notes
// - termination bit selects 100 ohm, else 50
// - half swing bit halves output swing
// - channel exchange bit low swaps a and b
// - sixteen lane polarity mask, reset zero
// - low register lanes 0-7, high reversed 8-15
// - upper power-down bits tristate lanes, d7 lane14
// - marker duty: one bitclk or half marker frame
// - marker on lane zero replaces data lsb
// - marker disable sends lsb on lane zero
// - edge swap exchanges rising and falling bits
// - scramble code 2 ovr lsb, 3 lsb+1
`timescale 1ns/100ps
module lofc_top (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [lofc_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [lofc_pkg::DATA_W-1:0]   pwdata,
  output logic      [lofc_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // sample stream from the converter core
  input  wire logic                          smp_valid,
  output logic                               smp_ready,
  input  wire logic [lofc_pkg::CH_W-1:0]     smp_a,
  input  wire logic [lofc_pkg::CH_W-1:0]     smp_b,
  input  wire logic                          smp_ovr,
  // lower lane power-down, held elsewhere
  input  wire logic [7:0]                    lane_pdn_low,
  // link pins
  input  wire logic                          forwarded_bit_clock,
  output logic      [lofc_pkg::LANES-1:0]    lane_data,
  output logic      [lofc_pkg::LANES-1:0]    lane_oe,
  // analog trims of the output drivers
  output logic                               term_100_sel,
  output logic                               half_swing
);
  import lofc_pkg::*;

  // register storage
  logic [7:0] link_ctrl_q, link_ctrl_d;     // output_link_control
  logic [7:0] inv_low_q, inv_low_d;         // lane_invert_low
  logic [7:0] inv_high_q, inv_high_d;       // lane_invert_high
  logic [7:0] pdn_a_q, pdn_a_d;             // lane_powerdown_upper_a
  logic [7:0] pdn_b_q, pdn_b_d;             // lane_powerdown_upper_b
  logic [7:0] marker_q, marker_d;           // frame_marker_control
  logic [7:0] mux_edge_q, mux_edge_d;       // output_mux_edge_scramble
  logic [DATA_W-1:0] prdata_q, prdata_d;    // read data, captured in setup
  // bus decode
  logic [IDX_W-1:0] idx;                    // word index of the access
  logic             hit;                    // mapped and aligned
  logic             wr_en;                  // write takes effect this edge
  // link side
  logic             bclk_s1_q, bclk_s2_q, bclk_s3_q;
  logic             rise_evt, fall_evt;     // detected bit clock edges
  logic [FRAME_W-1:0] frame_q, frame_d;     // bit-clock cycle within marker frame
  logic [LANES-1:0] lane_q, lane_d;         // driven lane levels
  logic [LANES-1:0] fall_hold_q, fall_hold_d;
  logic [LANES-1:0] oe_q, oe_d;
  // derived controls
  logic [LANES-1:0] lane_polarity_mask;   // per-lane inversion
  logic [LANES-1:0] lane_powerdown_mask;  // per-lane tristate request
  logic             marker_lvl, marker_on;
  logic [CH_W-1:0]  word_a, word_b, word_r, word_f;
  logic [SAMPLE_W-1:0] cur_smp;
  logic [LEVEL_W-1:0]  fifo_level;

  // fifo carriers
  lofc_stream_if #(.W(SAMPLE_W)) in_if ();
  lofc_stream_if #(.W(SAMPLE_W)) out_if ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // mapped-register check, shared by read and write paths
  function automatic logic is_mapped(input logic [IDX_W-1:0] i);
    return (i == IDX_LINK_CTRL) || (i == IDX_INV_LOW) || (i == IDX_INV_HIGH) ||
           (i == IDX_PDN_A) || (i == IDX_PDN_B) || (i == IDX_MARKER) ||
           (i == IDX_MUX_EDGE) || (i == IDX_STATUS);
  endfunction : is_mapped

  // masked write: reserved positions keep zero whatever software sends
  function automatic logic [7:0] reg_write(input logic [7:0] old_v,
                                           input logic       sel,
                                           input logic [7:0] wv,
                                           input logic [7:0] msk);
    return sel ? (wv & msk) : old_v;
  endfunction : reg_write

  // shape one channel word: ovr insertion, marker on lsb, polarity
  function automatic logic [CH_W-1:0] shape_word(input logic [CH_W-1:0]  d,
                                                 input logic             ovr,
                                                 input logic [SCR_W-1:0] scr,
                                                 input logic             mk_on,
                                                 input logic             mk,
                                                 input logic [LANES-1:0] inv);
    logic [CH_W-1:0] w;
    w = d;
    if (scr == SCR_OVR_LSB) begin
      w[0] = ovr;
    end else if (scr == SCR_OVR_LSB1) begin
      w[1] = ovr;
    end
    // marker takes lane zero, which carries the lsb
    if (mk_on) begin
      w[0] = mk;
    end
    return w ^ inv;
  endfunction : shape_word

  // ---------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped or unaligned
  // ---------------------------------------------------------------

  assign idx     = paddr[ADDR_W-1:2];
  assign hit     = is_mapped(idx) && (paddr[1:0] == 2'h0);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;
  assign prdata  = prdata_q;

  // read data is latched in the setup cycle so it comes from a flop
  always_comb begin
    prdata_d = prdata_q;
    if (psel && !penable) begin
      prdata_d = '0;
      if (paddr[1:0] == 2'h0) begin
        case (idx)
          IDX_LINK_CTRL: prdata_d[7:0] = link_ctrl_q;
          IDX_INV_LOW:   prdata_d[7:0] = inv_low_q;
          IDX_INV_HIGH:  prdata_d[7:0] = inv_high_q;
          IDX_PDN_A:     prdata_d[7:0] = pdn_a_q;
          IDX_PDN_B:     prdata_d[7:0] = pdn_b_q;
          IDX_MARKER:    prdata_d[7:0] = marker_q;
          IDX_MUX_EDGE:  prdata_d[7:0] = mux_edge_q;
          // status: fifo occupancy and bit-clock position in marker frame
          IDX_STATUS: begin
            prdata_d[LEVEL_W-1:0] = fifo_level;
            prdata_d[STAT_FRAME_LSB +: FRAME_W] = frame_q;
          end
          default:       prdata_d = '0;
        endcase
      end
    end
  end

  // register next values; status is read-only and ignores writes
  always_comb begin
    link_ctrl_d = reg_write(link_ctrl_q, wr_en && idx == IDX_LINK_CTRL, pwdata[7:0],
                            LINK_CTRL_MASK);
    inv_low_d   = reg_write(inv_low_q, wr_en && idx == IDX_INV_LOW, pwdata[7:0], INV_MASK);
    inv_high_d  = reg_write(inv_high_q, wr_en && idx == IDX_INV_HIGH, pwdata[7:0], INV_MASK);
    pdn_a_d     = reg_write(pdn_a_q, wr_en && idx == IDX_PDN_A, pwdata[7:0], PDN_A_MASK);
    pdn_b_d     = reg_write(pdn_b_q, wr_en && idx == IDX_PDN_B, pwdata[7:0], PDN_B_MASK);
    marker_d    = reg_write(marker_q, wr_en && idx == IDX_MARKER, pwdata[7:0], MARKER_MASK);
    mux_edge_d  = reg_write(mux_edge_q, wr_en && idx == IDX_MUX_EDGE, pwdata[7:0],
                            MUX_EDGE_MASK);
  end

  // register bank flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_ctrl_q <= LINK_CTRL_RST;
      inv_low_q   <= ZERO_RST;
      inv_high_q  <= ZERO_RST;
      pdn_a_q     <= ZERO_RST;
      pdn_b_q     <= ZERO_RST;
      marker_q    <= ZERO_RST;
      mux_edge_q  <= ZERO_RST;
      prdata_q    <= '0;
    end else begin
      link_ctrl_q <= link_ctrl_d;
      inv_low_q   <= inv_low_d;
      inv_high_q  <= inv_high_d;
      pdn_a_q     <= pdn_a_d;
      pdn_b_q     <= pdn_b_d;
      marker_q    <= marker_d;
      mux_edge_q  <= mux_edge_d;
      prdata_q    <= prdata_d;
    end
  end

  // driver trims go straight from the control register
  assign term_100_sel = link_ctrl_q[TERM_BIT];
  assign half_swing   = link_ctrl_q[HALF_SWING_BIT];

  // ---------------------------------------------------------------
  // lane maps
  // ---------------------------------------------------------------

  // low register in natural order, high register reversed onto 8..15
  always_comb begin
    lane_polarity_mask[7:0] = inv_low_q;
    for (int j = 0; j < 8; j++) begin
      lane_polarity_mask[8 + j] = inv_high_q[7 - j];
    end
  end

  // first register bits 7..1 cover lanes 14..8, second bit 0 lane 15
  assign lane_powerdown_mask = {pdn_b_q[0], pdn_a_q[7:1], lane_pdn_low};

  // ---------------------------------------------------------------
  // sample fifo: absorbs core bursts against the slower bit clock
  // ---------------------------------------------------------------

  assign in_if.valid  = smp_valid;
  assign in_if.data   = {smp_ovr, smp_b, smp_a};
  assign smp_ready    = in_if.ready;
  // one sample drains per bit-clock rising edge
  assign out_if.ready = rise_evt;

  lofc_fifo #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .wr    (in_if),
    .rd    (out_if),
    .level (fifo_level)
  );

  // ---------------------------------------------------------------
  // bit clock sampling; the first stage feeds only the second
  // ---------------------------------------------------------------

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
    end else begin
      bclk_s1_q <= forwarded_bit_clock;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
    end
  end

  assign rise_evt = bclk_s2_q & ~bclk_s3_q;
  assign fall_evt = ~bclk_s2_q & bclk_s3_q;

  // ---------------------------------------------------------------
  // lane formatter
  // ---------------------------------------------------------------

  // an empty fifo sends an all-zero sample so marker timing never slips
  assign cur_smp = out_if.valid ? out_if.data : '0;

  // channel exchange bit low swaps the two channels
  always_comb begin
    if (link_ctrl_q[CH_EXCH_BIT]) begin
      word_a = cur_smp[CH_W-1:0];
      word_b = cur_smp[2*CH_W-1:CH_W];
    end else begin
      word_a = cur_smp[2*CH_W-1:CH_W];
      word_b = cur_smp[CH_W-1:0];
    end
  end

  // marker level for the bit-clock cycle that starts now
  always_comb begin
    if (marker_q[MARKER_DUTY_BIT]) begin
      marker_lvl = (frame_d < FRAME_W'(FRAME_BITCLKS / 2));
    end else begin
      marker_lvl = (frame_d == '0);
    end
    marker_on = ~marker_q[MARKER_DIS_BIT];
  end

  // edge swap decides which channel rides the rising edge
  always_comb begin
    if (mux_edge_q[EDGE_SWAP_BIT]) begin
      word_r = word_b;
      word_f = word_a;
    end else begin
      word_r = word_a;
      word_f = word_b;
    end
  end

  // lane next values: rising edge loads both halves, falling shows the held one
  always_comb begin
    frame_d     = frame_q;
    lane_d      = lane_q;
    fall_hold_d = fall_hold_q;
    oe_d        = ~lane_powerdown_mask;
    if (rise_evt) begin
      frame_d = (frame_q == FRAME_W'(FRAME_BITCLKS - 1)) ? '0 : frame_q + FRAME_W'(1);
    end
    if (rise_evt) begin
      lane_d      = shape_word(word_r, cur_smp[SAMPLE_W-1], mux_edge_q[SCR_LSB +: SCR_W],
                               marker_on, marker_lvl, lane_polarity_mask);
      fall_hold_d = shape_word(word_f, cur_smp[SAMPLE_W-1], mux_edge_q[SCR_LSB +: SCR_W],
                               marker_on, marker_lvl, lane_polarity_mask);
    end else if (fall_evt) begin
      lane_d = fall_hold_q;
    end
  end

  // lane flops; frame counter starts one before zero so the first edge opens a marker frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q     <= FRAME_W'(FRAME_BITCLKS - 1);
      lane_q      <= '0;
      fall_hold_q <= '0;
      oe_q        <= '0;
    end else begin
      frame_q     <= frame_d;
      lane_q      <= lane_d;
      fall_hold_q <= fall_hold_d;
      oe_q        <= oe_d;
    end
  end

  assign lane_data = lane_q;
  assign lane_oe   = oe_q;
endmodule : lofc_top

// *** lofc_pkg.sv ***
// lofc_pkg: register map, field positions, reset values and sizes of the lvds output block
package lofc_pkg;
  // bus and lane geometry
  localparam int ADDR_W        = 12;
  localparam int DATA_W        = 32;
  localparam int LANES         = 16;
  localparam int CH_W          = 16;
  localparam int SAMPLE_W      = 2 * CH_W + 1;   // {ovr, channel b, channel a}
  localparam int FIFO_DEPTH    = 32;
  localparam int LEVEL_W       = 6;              // holds 0..FIFO_DEPTH
  localparam int FRAME_BITCLKS = 4;              // bit-clock cycles per marker frame
  localparam int FRAME_W       = 2;
  localparam int IDX_W         = 10;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LINK_CTRL  = 10'h110;
  localparam logic [IDX_W-1:0] IDX_INV_LOW    = 10'h111;
  localparam logic [IDX_W-1:0] IDX_INV_HIGH   = 10'h112;
  localparam logic [IDX_W-1:0] IDX_PDN_A      = 10'h113;
  localparam logic [IDX_W-1:0] IDX_PDN_B      = 10'h114;
  localparam logic [IDX_W-1:0] IDX_MARKER     = 10'h115;
  localparam logic [IDX_W-1:0] IDX_MUX_EDGE   = 10'h116;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 10'h120;
  // field positions
  localparam int TERM_BIT        = 7;
  localparam int HALF_SWING_BIT  = 5;
  localparam int CH_EXCH_BIT     = 1;
  localparam int MARKER_DUTY_BIT = 3;
  localparam int MARKER_DIS_BIT  = 2;
  localparam int EDGE_SWAP_BIT   = 6;
  localparam int SCR_LSB         = 0;
  localparam int SCR_W           = 3;
  localparam int STAT_FRAME_LSB  = 8;
  // writable bit masks; all other positions store nothing and read zero
  localparam logic [7:0] LINK_CTRL_MASK = 8'hA2;
  localparam logic [7:0] INV_MASK       = 8'hFF;
  localparam logic [7:0] PDN_A_MASK     = 8'hFE;
  localparam logic [7:0] PDN_B_MASK     = 8'h01;
  localparam logic [7:0] MARKER_MASK    = 8'h0C;
  localparam logic [7:0] MUX_EDGE_MASK  = 8'hC7;
  // reset values
  localparam logic [7:0] LINK_CTRL_RST  = 8'h02;
  localparam logic [7:0] ZERO_RST       = 8'h00;
  // lsb handling codes
  localparam logic [SCR_W-1:0] SCR_OVR_LSB  = 3'h2;
  localparam logic [SCR_W-1:0] SCR_OVR_LSB1 = 3'h3;
endpackage : lofc_pkg

// *** lofc_stream_if.sv ***
// lofc_stream_if: valid/ready word stream between the block's own modules
`timescale 1ns/100ps
interface lofc_stream_if #(parameter int W = 33) ();
  logic         valid;  // word offered
  logic         ready;  // word accepted
  logic [W-1:0] data;   // payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : lofc_stream_if

// *** lofc_fifo.sv ***
// lofc_fifo: synchronous sample fifo with valid/ready on both sides
`timescale 1ns/100ps
module lofc_fifo #(
  parameter int W     = 33,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // fill and drain sides
  lofc_stream_if.snk                wr,
  lofc_stream_if.src                rd,
  // occupancy
  output logic [$clog2(DEPTH):0]    level
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];          // sample storage
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // full and empty come straight from the count, so they never lie
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem[rp_q];
  assign level    = cnt_q;
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  // pointer and count next values
  always_comb begin
    wp_d  = push ? wp_q + AW'(1) : wp_q;
    rp_d  = pop ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // pointer and count registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end
endmodule : lofc_fifo

// *** lofc_monitor.sv ***
// lofc_monitor: port checks for lofc_top
`timescale 1ns/100ps
module lofc_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb requests
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // link side
  input wire logic [7:0]  lane_pdn_low,
  input wire logic        forwarded_bit_clock,
  input wire logic [15:0] lane_data,
  input wire logic [15:0] lane_oe,
  input wire logic        term_100_sel,
  input wire logic        half_swing
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;     // a write completes at this edge
  logic wr_ctl; // that write hits the link control word
  assign wr = psel && penable && pwrite;
  assign wr_ctl = wr && paddr == 12'h440;
  // analog trims follow the control word and move for no other cause
  property p_term; wr_ctl |=> term_100_sel == $past(pwdata[7]); endproperty
  a_term: assert property (p_term) else $error("term select wrong");
  property p_term_hold; $changed(term_100_sel) |-> $past(wr_ctl); endproperty
  a_term_hold: assert property (p_term_hold) else $error("term select moved");
  property p_swing; wr_ctl |=> half_swing == $past(pwdata[5]); endproperty
  a_swing: assert property (p_swing) else $error("half swing wrong");
  property p_swing_hold; $changed(half_swing) |-> $past(wr_ctl); endproperty
  a_swing_hold: assert property (p_swing_hold) else $error("half swing moved");
  // power-down bits take lanes off the wire two edges after the write
  property p_pdn_a;
    wr && paddr == 12'h44C |-> ##2 lane_oe[14:8] == ~$past(pwdata[7:1], 2);
  endproperty
  a_pdn_a: assert property (p_pdn_a) else $error("lanes 8-14 enable wrong");
  property p_pdn_b; wr && paddr == 12'h450 |-> ##2 lane_oe[15] == !$past(pwdata[0], 2);
  endproperty
  a_pdn_b: assert property (p_pdn_b) else $error("lane 15 enable wrong");
  property p_pdn_low; $past(presetn) |-> lane_oe[7:0] == ~$past(lane_pdn_low); endproperty
  a_pdn_low: assert property (p_pdn_low) else $error("lanes 0-7 enable wrong");
  // lanes move only after a bit-clock edge has crossed the synchroniser
  property p_lane_time;
    $changed(lane_data) |-> $past(forwarded_bit_clock, 3) != $past(forwarded_bit_clock, 4)
      || $past(forwarded_bit_clock, 4) != $past(forwarded_bit_clock, 5)
      || $past(forwarded_bit_clock, 5) != $past(forwarded_bit_clock, 6);
  endproperty
  a_lane_time: assert property (p_lane_time) else $error("lanes moved off edge");
endmodule : lofc_monitor
bind lofc_top lofc_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .lane_pdn_low, .forwarded_bit_clock, .lane_data, .lane_oe, .term_100_sel, .half_swing);

// *** lofc_rx_model.sv ***
// lofc_rx_model: receiver at the far end of the lanes, makes the bit clock in bursts
`timescale 1ns/100ps
module lofc_rx_model (
  // burst request
  input  wire logic        go,
  input  wire logic [7:0]  burst,
  // link pins
  output logic             bit_clk,
  input  wire logic [15:0] lane_data,
  input  wire logic [15:0] lane_oe,
  // captured words
  output logic [15:0]      word_rise,
  output logic [15:0]      word_fall,
  output int               n_cap
);
  logic [15:0] lvl; // level on each pair; a released pair has no bias, so it reads inverted
  always_comb for (int i = 0; i < 16; i++) lvl[i] = lane_oe[i] ? lane_data[i] : ~lane_data[i];
  initial begin
    bit_clk = 1'b0;
    n_cap = 0;
  end
  // clock stands still low between bursts; offset keeps it off pclk edges
  always @(posedge go) begin
    #1.3;
    repeat (burst) begin
      bit_clk = 1'b1;
      #16;
      bit_clk = 1'b0;
      #16;
    end
  end
  // sample late in each word, after the synchroniser delay has passed
  always @(posedge bit_clk) begin
    #22 word_rise = lvl;
  end
  always @(negedge bit_clk) begin
    #22 word_fall = lvl;
    n_cap++;
  end
endmodule : lofc_rx_model

// *** tb_top.sv ***
// tb_top: register, power-down, lane format and fifo tests of lofc_top
`timescale 1ns/100ps
module tb_top;
  import lofc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, go;
  logic        smp_valid, smp_ready, smp_ovr, forwarded_bit_clock, term_100_sel, half_swing;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] smp_a, smp_b, sa, sb, ea, eb, lane_data, lane_oe, word_rise, word_fall;
  logic [7:0]  lane_pdn_low, burst, lk, lo, hi, mk, mx;
  int          n_cap, n_fail, n_compared, n;
  // per pass: link control, invert low, invert high, marker, mux and edge
  logic [39:0] cfg [5] = '{40'h0200000000, 40'h00A5010840, 40'h0200800402, 40'h023C000403,
                           40'hA200000002};
  logic [7:0]  rst_v [7] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  msk_v [7] = '{8'hA2, 8'hFF, 8'hFF, 8'hFE, 8'h01, 8'h0C, 8'hC7};
  lofc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .smp_valid, .smp_ready, .smp_a, .smp_b, .smp_ovr, .lane_pdn_low,
    .forwarded_bit_clock, .lane_data, .lane_oe, .term_100_sel, .half_swing);
  lofc_rx_model rx (.go, .burst, .bit_clk(forwarded_bit_clock), .lane_data, .lane_oe,
    .word_rise, .word_fall, .n_cap);
  always #2 pclk = ~pclk;
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      n_fail++;
    end
  endtask : chk
  // a bound ran out: count it and close the run
  task automatic stuck(input string nm);
    chk(nm, 1, 0);
    conclude();
  endtask : stuck
  // one apb transfer; result lands in r and e
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (k >= 64) stuck("apb answer");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic push(input logic [15:0] a, input logic [15:0] b, input logic o);
    int k;
    @(posedge pclk);
    smp_valid <= 1'b1;
    smp_a <= a;
    smp_b <= b;
    smp_ovr <= o;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (smp_ready !== 1'b1 && k < 64);
    if (k >= 64) stuck("sample accept");
    smp_valid <= 1'b0;
  endtask : push
  task automatic wait_cap(input int t);
    int k;
    k = 0;
    while (n_cap < t && k < 1000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 1000) stuck("bit clock capture");
  endtask : wait_cap
  // expected lane word: lsb insertion, then marker, then polarity
  function automatic logic [15:0] shape(input logic [15:0] w, input logic o, input int c);
    logic [15:0] v;
    v = w;
    if (mx[2:0] == 3'h2) v[0] = o;
    if (mx[2:0] == 3'h3) v[1] = o;
    if (!mk[2]) v[0] = (c == 0) || (mk[3] && c == 1);
    v[7:0] = v[7:0] ^ lo;
    for (int j = 0; j < 8; j++) v[8 + j] = v[8 + j] ^ hi[7 - j];
    return v;
  endfunction : shape
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, smp_valid, smp_ovr, go} = '0;
    {paddr, pwdata, smp_a, smp_b} = '0;
    lane_pdn_low = 8'h0F;
    burst = 8'h04;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 12'h440 + 12'(4 * i), '0);
      chk("reset value", rst_v[i], r);
      apb(1'b1, 12'h440 + 12'(4 * i), 32'hFFFF_FFFF);
      apb(1'b0, 12'h440 + 12'(4 * i), '0);
      chk("masked readback", msk_v[i], r);
    end
    chk("term select", 1, term_100_sel);
    chk("half swing", 1, half_swing);
    chk("upper enables", 8'h00, lane_oe[15:8]);
    chk("lower enables", 8'hF0, lane_oe[7:0]);
    apb(1'b1, 12'h44C, 32'h0000_0080);
    apb(1'b1, 12'h450, '0);
    apb(1'b0, 12'h45C, '0);
    chk("unmapped error", 1, e);
    chk("unmapped data", '0, r);
    apb(1'b0, 12'h441, '0);
    chk("unaligned error", 1, e);
    chk("upper enables", 8'hBF, lane_oe[15:8]);
    apb(1'b1, 12'h44C, '0);
    lane_pdn_low <= 8'h00;
    for (int i = 0; i < 5; i++) begin
      {lk, lo, hi, mk, mx} = cfg[i];
      apb(1'b1, 12'h440, {24'h0, lk});
      apb(1'b1, 12'h444, {24'h0, lo});
      apb(1'b1, 12'h448, {24'h0, hi});
      apb(1'b1, 12'h454, {24'h0, mk});
      apb(1'b1, 12'h458, {24'h0, mx});
      for (int c = 0; c < 4; c++) push(16'hC3A0 + 16'(c), 16'h5B1C - 16'(c), c[0]);
      n = n_cap;
      go <= 1'b1;
      for (int c = 0; c < 4; c++) begin
        wait_cap(n + c + 1);
        sa = 16'hC3A0 + 16'(c);
        sb = 16'h5B1C - 16'(c);
        ea = lk[1] ? sa : sb;
        eb = lk[1] ? sb : sa;
        if (mx[6]) {ea, eb} = {eb, ea};
        chk("rise word", shape(ea, c[0], c), word_rise);
        chk("fall word", shape(eb, c[0], c), word_fall);
      end
      go <= 1'b0;
    end
    // fill with the far side stalled, then drain
    burst <= 8'h20;
    @(posedge pclk);
    smp_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      if (smp_ready === 1'b1) n++;
    end while (smp_ready === 1'b1 && n < 40);
    smp_valid <= 1'b0;
    chk("accepted until full", FIFO_DEPTH, n);
    apb(1'b0, 12'h480, '0);
    chk("full level", 6'h20, r[5:0]);
    n = n_cap;
    go <= 1'b1;
    wait_cap(n + 32);
    go <= 1'b0;
    apb(1'b0, 12'h480, '0);
    chk("drained level", 6'h00, r[5:0]);
    conclude();
  end
endmodule : tb_top
